/* include/pin_mux_pkg.sv */
// Purpose: shared constants and carriers for the shared pin function select
// Assumes: one system clock, no register bus
// Notes: port G bit positions name the shared functions on each pin
package pin_mux_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int PORTG_W = 8;
    localparam int CAPTURE_W = 4;
    localparam int IRQ_W = 8;
    localparam int SYNC_STAGES = 3;

    // ------------------------------------------------------------
    // port g bit positions
    // ------------------------------------------------------------
    localparam int PG_TRIG_BIT = 4;
    localparam int PG_RX_BIT = 5;
    localparam int PG_TX_BIT = 6;
    localparam int PG_CLK_BIT = 7;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic PAD_OUT_RST = 1'h0;
    localparam logic PAD_OE_RST = 1'h0;
    localparam logic [7:0] PORTG_RST = 8'h00;
    localparam logic SYNC_RST = 1'h0;
    localparam logic OPEN_DRAIN_LOW = 1'h0;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic out;
        logic oe;
    } pad_drive_t;

    typedef struct packed {
        logic [7:0] data;
        logic [7:0] dir;
    } portg_ctrl_t;

    typedef struct packed {
        logic data;
        logic dir;
    } port_bit_ctrl_t;

    typedef struct packed {
        logic rx_en;
        logic tx_en;
        logic tx;
        logic clk_oe;
        logic clk_out;
    } serial_c_ctrl_t;

    // ------------------------------------------------------------
    // shared pin 71 owner
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        OWN_TWOWIRE = 2'b00,
        OWN_ADDR = 2'b01,
        OWN_PORT = 2'b10
    } pin71_owner_t;

endpackage : pin_mux_pkg

/* src/pin_sync.sv */
// Purpose: three stage pin synchroniser with agreement filter
// Assumes: inputs arrive from pins outside the system clock domain
// Notes: output moves only once stages two and three agree
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // pins and filtered result
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] level_o
);

    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] level_reg;
    logic [WIDTH-1:0] level_next;

    // ------------------------------------------------------------
    // agreement filter
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            level_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : level_reg[i];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s1_reg <= {WIDTH{pin_mux_pkg::SYNC_RST}};
            s2_reg <= {WIDTH{pin_mux_pkg::SYNC_RST}};
            s3_reg <= {WIDTH{pin_mux_pkg::SYNC_RST}};
            level_reg <= {WIDTH{pin_mux_pkg::SYNC_RST}};
        end else begin
            s1_reg <= pin_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level_reg <= level_next;
        end
    end

    assign level_o = level_reg;

endmodule : pin_sync

/* src/shared_pin_function_select.sv */
// Purpose: function select for the top address / two-wire clock pin and port g pins
// Assumes: all peripheral and port controls come from the system clock domain
// Notes: pad drives and peripheral inputs are registered; pins pass a three stage sync
`timescale 1ns/10ps
// Contract
// R01 - With the second two-wire channel on, its clock pin is open drain and the port driver stays off unless enabled.
// R02 - The shared pin carries the top address bit only with two-wire off and the external bus using it.
// R03 - With two-wire off and the address line unused, the shared pin is a port bit.
// R04 - Each of the eight external interrupts samples its pin continuously while enabled, port output off unless driven.
// R05 - The four capture inputs follow their pins continuously while selected, port output off; the code leaves the pin to the port data and direction.
// R06 - The converter start trigger follows its pin continuously while selected, port output undriven; the code leaves the pin to the port data and direction.
// R07 - The free-run timer external clock follows its pin continuously while selected, port output off; the code leaves the pin to the port data and direction.
// R08 - The third serial receiver follows its data-in pin continuously while receiving, port output off; the code leaves the pin to the port data and direction.
// R09 - The third serial transmit drives its pin only while its data output enable is set.
// R10 - The third serial clock drives its pin only while its clock output enable is set.
// R11 - A pin with no peripheral output takes direction and value from the port data and direction.
module shared_pin_function_select #(
    parameter int PORTG_W = pin_mux_pkg::PORTG_W,
    parameter int CAPTURE_W = pin_mux_pkg::CAPTURE_W
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // shared top address / two-wire clock pin
    input wire logic addr_top_bit_pin_i,
    output pin_mux_pkg::pad_drive_t addr_top_bit_pin_o,
    // two-wire channel b
    input wire logic twowire_b_enable_i,
    input wire logic twowire_b_clock_out_i,
    output logic twowire_b_clock_pin_o,
    // external bus top address bit
    input wire logic extbus_addr_top_used_i,
    input wire logic addr_top_bit_i,
    // port 6 bit 7
    input wire pin_mux_pkg::port_bit_ctrl_t port6_bit7_i,
    output logic port6_bit7_o,
    // port g pins and control
    input wire logic [PORTG_W-1:0] portg_pin_i,
    output logic [PORTG_W-1:0] portg_pin_out_o,
    output logic [PORTG_W-1:0] portg_pin_oe_o,
    input wire pin_mux_pkg::portg_ctrl_t portg_ctrl_i,
    output logic [PORTG_W-1:0] portg_in_o,
    // external interrupts
    input wire logic [PORTG_W-1:0] ext_irq_en_i,
    output logic [PORTG_W-1:0] ext_irq_o,
    // input capture
    input wire logic [CAPTURE_W-1:0] capture_sel_i,
    output logic [CAPTURE_W-1:0] capture_inputs_o,
    // converter trigger and free-run clock
    input wire logic converter_trig_sel_i,
    output logic converter_start_trigger_o,
    input wire logic freerun_ext_sel_i,
    output logic freerun_ext_clock_o,
    // serial channel c
    input wire pin_mux_pkg::serial_c_ctrl_t serial_c_ctrl_i,
    output logic serial_c_rx_o,
    output logic serial_c_clock_in_o
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [PORTG_W-1:0] portg_sync;
    logic pin71_sync;
    pin_mux_pkg::pin71_owner_t owner;
    pin_mux_pkg::pad_drive_t pin71_reg;
    pin_mux_pkg::pad_drive_t pin71_next;
    logic [PORTG_W-1:0] portg_out_reg;
    logic [PORTG_W-1:0] portg_out_next;
    logic [PORTG_W-1:0] portg_oe_reg;
    logic [PORTG_W-1:0] portg_oe_next;
    logic [PORTG_W-1:0] drv_out;
    logic [PORTG_W-1:0] drv_oe;
    logic twowire_clk_reg;
    logic twowire_clk_next;
    logic port67_in_reg;
    logic port67_in_next;
    logic [PORTG_W-1:0] portg_in_reg;
    logic [PORTG_W-1:0] irq_reg;
    logic [PORTG_W-1:0] irq_next;
    logic [CAPTURE_W-1:0] cap_reg;
    logic [CAPTURE_W-1:0] cap_next;
    logic trig_reg;
    logic trig_next;
    logic frun_clk_reg;
    logic frun_clk_next;
    logic rx_reg;
    logic rx_next;
    logic sck_in_reg;
    logic sck_in_next;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    pin_sync #(
        .WIDTH(PORTG_W + 1)
    ) u_pin_sync (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .pin_i({addr_top_bit_pin_i, portg_pin_i}),
        .level_o({pin71_sync, portg_sync})
    );

    // ------------------------------------------------------------
    // shared top address pin
    // ------------------------------------------------------------
    always_comb begin
        if (twowire_b_enable_i) begin
            owner = pin_mux_pkg::OWN_TWOWIRE;
        end else if (extbus_addr_top_used_i) begin
            owner = pin_mux_pkg::OWN_ADDR; // R02
        end else begin
            owner = pin_mux_pkg::OWN_PORT; // R03
        end
    end

    always_comb begin
        pin71_next.out = pin_mux_pkg::PAD_OUT_RST;
        pin71_next.oe = pin_mux_pkg::PAD_OE_RST;
        case (owner)
            pin_mux_pkg::OWN_TWOWIRE: begin
                // open drain: only pulls low, port driver only if asked
                pin71_next.out = pin_mux_pkg::OPEN_DRAIN_LOW; // R01
                pin71_next.oe = !twowire_b_clock_out_i ||
                    (port6_bit7_i.dir && !port6_bit7_i.data); // R01
            end
            pin_mux_pkg::OWN_ADDR: begin
                pin71_next.out = addr_top_bit_i; // R02
                pin71_next.oe = 1'h1; // R02
            end
            pin_mux_pkg::OWN_PORT: begin
                pin71_next.out = port6_bit7_i.data; // R03
                pin71_next.oe = port6_bit7_i.dir; // R03
            end
            default: begin
                pin71_next.out = pin_mux_pkg::PAD_OUT_RST;
                pin71_next.oe = pin_mux_pkg::PAD_OE_RST;
            end
        endcase
        twowire_clk_next = twowire_b_enable_i ? pin71_sync : twowire_clk_reg; // R01
        port67_in_next = pin71_sync;
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin71_reg.out <= pin_mux_pkg::PAD_OUT_RST;
            pin71_reg.oe <= pin_mux_pkg::PAD_OE_RST;
            twowire_clk_reg <= pin_mux_pkg::SYNC_RST;
            port67_in_reg <= pin_mux_pkg::SYNC_RST;
        end else begin
            pin71_reg <= pin71_next;
            twowire_clk_reg <= twowire_clk_next;
            port67_in_reg <= port67_in_next;
        end
    end

    // ------------------------------------------------------------
    // port g output select per bit
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < PORTG_W; gi++) begin : g_portg_drv
            always_comb begin
                if (gi == pin_mux_pkg::PG_TX_BIT && serial_c_ctrl_i.tx_en) begin
                    drv_out[gi] = serial_c_ctrl_i.tx; // R09
                    drv_oe[gi] = 1'h1; // R09
                end else if (gi == pin_mux_pkg::PG_CLK_BIT && serial_c_ctrl_i.clk_oe) begin
                    drv_out[gi] = serial_c_ctrl_i.clk_out; // R10
                    drv_oe[gi] = 1'h1; // R10
                end else begin
                    // input functions leave the pin to the port settings
                    drv_out[gi] = portg_ctrl_i.data[gi]; // R11 R04 R05 R06 R07 R08
                    drv_oe[gi] = portg_ctrl_i.dir[gi]; // R11 R04 R05 R06 R07 R08
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // peripheral inputs from port g pins
    // ------------------------------------------------------------
    always_comb begin
        portg_out_next = drv_out;
        portg_oe_next = drv_oe;
        irq_next = portg_sync & ext_irq_en_i; // R04
        cap_next = portg_sync[CAPTURE_W-1:0] & capture_sel_i; // R05
        trig_next = portg_sync[pin_mux_pkg::PG_TRIG_BIT] & converter_trig_sel_i; // R06
        frun_clk_next = portg_sync[pin_mux_pkg::PG_TRIG_BIT] & freerun_ext_sel_i; // R07
        rx_next = serial_c_ctrl_i.rx_en ? portg_sync[pin_mux_pkg::PG_RX_BIT] : rx_reg; // R08
        // clock pin serves as input when not driven
        sck_in_next = serial_c_ctrl_i.clk_oe ? sck_in_reg : portg_sync[pin_mux_pkg::PG_CLK_BIT]; // R10
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            portg_out_reg <= PORTG_W'(pin_mux_pkg::PORTG_RST);
            portg_oe_reg <= PORTG_W'(pin_mux_pkg::PORTG_RST);
            portg_in_reg <= PORTG_W'(pin_mux_pkg::PORTG_RST);
            irq_reg <= PORTG_W'(pin_mux_pkg::PORTG_RST);
            cap_reg <= CAPTURE_W'(pin_mux_pkg::PORTG_RST);
            trig_reg <= pin_mux_pkg::SYNC_RST;
            frun_clk_reg <= pin_mux_pkg::SYNC_RST;
            rx_reg <= pin_mux_pkg::SYNC_RST;
            sck_in_reg <= pin_mux_pkg::SYNC_RST;
        end else begin
            portg_out_reg <= portg_out_next;
            portg_oe_reg <= portg_oe_next;
            portg_in_reg <= portg_sync;
            irq_reg <= irq_next;
            cap_reg <= cap_next;
            trig_reg <= trig_next;
            frun_clk_reg <= frun_clk_next;
            rx_reg <= rx_next;
            sck_in_reg <= sck_in_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign addr_top_bit_pin_o = pin71_reg;
    assign twowire_b_clock_pin_o = twowire_clk_reg;
    assign port6_bit7_o = port67_in_reg;
    assign portg_pin_out_o = portg_out_reg;
    assign portg_pin_oe_o = portg_oe_reg;
    assign portg_in_o = portg_in_reg;
    assign ext_irq_o = irq_reg;
    assign capture_inputs_o = cap_reg;
    assign converter_start_trigger_o = trig_reg;
    assign freerun_ext_clock_o = frun_clk_reg;
    assign serial_c_rx_o = rx_reg;
    assign serial_c_clock_in_o = sck_in_reg;

endmodule : shared_pin_function_select

/* test/pin_mux_checker.sv */
// Purpose: concurrent checks on the shared pin select ports
// Assumes: one clock; pads and gated inputs registered one edge after controls
// Notes: checks wait two edges after each reset release
`timescale 1ns/10ps
module pin_mux_checker (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // controls and pins
    input wire logic twowire_b_enable_i,
    input wire logic twowire_b_clock_out_i,
    input wire logic extbus_addr_top_used_i,
    input wire logic addr_top_bit_i,
    input wire pin_mux_pkg::port_bit_ctrl_t port6_bit7_i,
    input wire pin_mux_pkg::portg_ctrl_t portg_ctrl_i,
    input wire logic [7:0] portg_pin_i,
    input wire logic [7:0] ext_irq_en_i,
    input wire logic [3:0] capture_sel_i,
    input wire logic converter_trig_sel_i,
    input wire logic freerun_ext_sel_i,
    input wire pin_mux_pkg::serial_c_ctrl_t serial_c_ctrl_i,
    // watched outputs
    input wire pin_mux_pkg::pad_drive_t addr_top_bit_pin_o,
    input wire logic [7:0] portg_pin_out_o,
    input wire logic [7:0] portg_pin_oe_o,
    input wire logic [7:0] portg_in_o,
    input wire logic [7:0] ext_irq_o,
    input wire logic [3:0] capture_inputs_o,
    input wire logic converter_start_trigger_o,
    input wire logic freerun_ext_clock_o,
    input wire logic serial_c_rx_o,
    input wire logic twowire_b_clock_pin_o,
    input wire logic port6_bit7_o,
    input wire logic serial_c_clock_in_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    logic [1:0] arm_reg;
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) arm_reg <= 2'h0;
        else arm_reg <= {arm_reg[0], 1'h1};
    end
    wire logic ok = arm_reg[1];
    sequence pins_steady;
        (ok && $stable(portg_pin_i))[*6];
    endsequence
    AST_TWOWIRE: assert property (
        ok && $past(twowire_b_enable_i) |-> addr_top_bit_pin_o == {1'h0,
        !$past(twowire_b_clock_out_i) || ($past(port6_bit7_i.dir) && !$past(port6_bit7_i.data))})
        else $error("two-wire pad wrong");
    AST_ADDR: assert property (
        ok && !$past(twowire_b_enable_i) && $past(extbus_addr_top_used_i)
        |-> addr_top_bit_pin_o == {$past(addr_top_bit_i), 1'h1}) else $error("address pad wrong");
    AST_PORT71: assert property (
        ok && !$past(twowire_b_enable_i) && !$past(extbus_addr_top_used_i)
        |-> addr_top_bit_pin_o == $past(port6_bit7_i)) else $error("port pad wrong");
    AST_TX: assert property (
        ok |-> {portg_pin_out_o[6], portg_pin_oe_o[6]} == ($past(serial_c_ctrl_i.tx_en) ?
        {$past(serial_c_ctrl_i.tx), 1'h1} : {$past(portg_ctrl_i.data[6]), $past(portg_ctrl_i.dir[6])}))
        else $error("tx pad wrong");
    AST_CLK: assert property (
        ok |-> {portg_pin_out_o[7], portg_pin_oe_o[7]} == ($past(serial_c_ctrl_i.clk_oe) ?
        {$past(serial_c_ctrl_i.clk_out), 1'h1} : {$past(portg_ctrl_i.data[7]), $past(portg_ctrl_i.dir[7])}))
        else $error("clock pad wrong");
    AST_PORTG: assert property (
        ok |-> portg_pin_out_o[5:0] == $past(portg_ctrl_i.data[5:0])
        && portg_pin_oe_o[5:0] == $past(portg_ctrl_i.dir[5:0])) else $error("port g pad wrong");
    AST_IRQ: assert property (
        ok |-> ext_irq_o == (portg_in_o & $past(ext_irq_en_i))) else $error("irq gate wrong");
    AST_CAPTURE: assert property (
        ok |-> capture_inputs_o == (portg_in_o[3:0] & $past(capture_sel_i))) else $error("capture wrong");
    AST_BIT4: assert property (
        ok |-> converter_start_trigger_o == (portg_in_o[4] && $past(converter_trig_sel_i))
        && freerun_ext_clock_o == (portg_in_o[4] && $past(freerun_ext_sel_i))) else $error("bit four wrong");
    AST_RX: assert property (
        ok |-> ($past(serial_c_ctrl_i.rx_en) ? serial_c_rx_o == portg_in_o[5] : $stable(serial_c_rx_o)))
        else $error("rx wrong");
    AST_SYNC: assert property (
        pins_steady |-> portg_in_o == portg_pin_i) else $error("pin level not followed");
    AST_TWOWIRE_IN: assert property (
        ok |-> ($past(twowire_b_enable_i) ? twowire_b_clock_pin_o == port6_bit7_o : $stable(twowire_b_clock_pin_o)))
        else $error("two-wire clock input wrong");
    AST_SCK_IN: assert property (
        ok |-> ($past(serial_c_ctrl_i.clk_oe) ? $stable(serial_c_clock_in_o) : serial_c_clock_in_o == portg_in_o[7]))
        else $error("serial clock input wrong");
endmodule : pin_mux_checker
bind shared_pin_function_select pin_mux_checker chk (.*);

/* test/board_model.sv */
// Purpose: board side of the shared pins
// Assumes: pull-up on the two-wire clock line, none on port g
// Notes: a released port g pin with no board driver toggles each cycle
`timescale 1ns/10ps
module board_model (
    // clock
    input wire logic clk_sys_i,
    // pads from the device
    input wire pin_mux_pkg::pad_drive_t pin71_pad_i,
    input wire logic [7:0] pad_out_i,
    input wire logic [7:0] pad_oe_i,
    // board drivers
    input wire logic pull_low_i,
    input wire logic [7:0] ext_lvl_i,
    input wire logic [7:0] ext_en_i,
    // wire levels
    output logic pin71_o,
    output logic [7:0] portg_o
);
    logic [7:0] float_reg = 8'h55;
    always_ff @(posedge clk_sys_i) float_reg <= ~float_reg;
    assign pin71_o = ((pin71_pad_i.oe && !pin71_pad_i.out) || pull_low_i) ? 1'h0 : 1'h1;
    assign portg_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ((ext_en_i & ext_lvl_i) | (~ext_en_i & float_reg)));
endmodule : board_model

/* test/shared_pin_function_select_tb.sv */
// Purpose: random and corner tests of the shared pin select
// Assumes: pads one edge after controls, inputs settle in five edges
// Notes: inputs driven at the falling edge
`timescale 1ns/10ps
module shared_pin_function_select_tb;
    logic clk = 1'h0, rstn = 1'h0, tw_en, tw_clk, bus_used, addr_bit, pull_low, trig_sel, fr_sel;
    pin_mux_pkg::port_bit_ctrl_t port67;
    pin_mux_pkg::portg_ctrl_t pg;
    pin_mux_pkg::serial_c_ctrl_t sc;
    pin_mux_pkg::pad_drive_t pad71;
    logic [7:0] irq_en, ext_lvl, ext_en = 8'hff, pg_out, pg_oe, pg_in, irq, pg_pin, l;
    logic [3:0] cap_sel, cap;
    logic scl_in, port67_in, pin71, trig, frclk, rx, ckin;
    int n_fail = 0, num_checks = 0, seed = 32'h7d6f4952;
    always #12.5 clk = ~clk;
    shared_pin_function_select dut (.clk_sys_i(clk), .rstn_i(rstn), .addr_top_bit_pin_i(pin71),
        .addr_top_bit_pin_o(pad71), .twowire_b_enable_i(tw_en), .twowire_b_clock_out_i(tw_clk),
        .twowire_b_clock_pin_o(scl_in), .extbus_addr_top_used_i(bus_used), .addr_top_bit_i(addr_bit),
        .port6_bit7_i(port67), .port6_bit7_o(port67_in), .portg_pin_i(pg_pin), .portg_pin_out_o(pg_out),
        .portg_pin_oe_o(pg_oe), .portg_ctrl_i(pg), .portg_in_o(pg_in), .ext_irq_en_i(irq_en),
        .ext_irq_o(irq), .capture_sel_i(cap_sel), .capture_inputs_o(cap), .converter_trig_sel_i(trig_sel),
        .converter_start_trigger_o(trig), .freerun_ext_sel_i(fr_sel), .freerun_ext_clock_o(frclk),
        .serial_c_ctrl_i(sc), .serial_c_rx_o(rx), .serial_c_clock_in_o(ckin));
    board_model board (.clk_sys_i(clk), .pin71_pad_i(pad71), .pad_out_i(pg_out), .pad_oe_i(pg_oe),
        .pull_low_i(pull_low), .ext_lvl_i(ext_lvl), .ext_en_i(ext_en), .pin71_o(pin71), .portg_o(pg_pin));
    // ------------------------------------------------------------
    // expectations and helpers
    // ------------------------------------------------------------
    function automatic logic [1:0] exp71();
        if (tw_en) return {1'h0, !tw_clk || (port67.dir && !port67.data)};
        if (bus_used) return {addr_bit, 1'h1};
        return {port67.data, port67.dir};
    endfunction : exp71
    function automatic logic exp_pin71();
        logic [1:0] e;
        e = exp71();
        return !((e[0] && !e[1]) || pull_low);
    endfunction : exp_pin71
    function automatic logic [15:0] exp_pg();
        logic [7:0] o, e;
        o = pg.data;
        e = pg.dir;
        if (sc.tx_en) begin
            o[6] = sc.tx;
            e[6] = 1'h1;
        end
        if (sc.clk_oe) begin
            o[7] = sc.clk_out;
            e[7] = 1'h1;
        end
        return {o, e};
    endfunction : exp_pg
    function automatic logic [7:0] exp_lvl();
        logic [15:0] p;
        p = exp_pg();
        return (p[15:8] & p[7:0]) | (ext_lvl & ~p[7:0]);
    endfunction : exp_lvl
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rnd();
        logic [31:0] a, b;
        a = $random(seed);
        b = $random(seed);
        {tw_en, tw_clk, bus_used, addr_bit, trig_sel, fr_sel, port67, cap_sel, sc, irq_en} = a[24:0];
        pg = b[15:0];
        ext_lvl = b[23:16];
        pull_low = tw_en & b[24];
    endtask : rnd
    task automatic end_sim();
        $display("checks=%0d fails=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        #100us;
        n_fail++;
        end_sim();
    end
    initial begin
        rnd();
        repeat (10) @(negedge clk);
        chk({pad71, pg_oe, irq}, 24'h0);
        rstn = 1'h1;
        repeat (2) @(negedge clk);
        repeat (300) begin
            rnd();
            @(negedge clk);
            chk({6'h0, pad71, pg_out, pg_oe}, {6'h0, exp71(), exp_pg()});
        end
        $display("test pads done");
        repeat (80) begin
            rnd();
            repeat (7) @(negedge clk);
            l = exp_lvl();
            chk(pg_in, l);
            chk(port67_in, exp_pin71());
            chk(irq, l & irq_en);
            chk(cap, l[3:0] & cap_sel);
            chk({trig, frclk}, {l[4] & trig_sel, l[4] & fr_sel});
            if (sc.rx_en) chk(rx, l[5]);
            if (!sc.clk_oe) chk(ckin, l[7]);
            if (tw_en) chk(scl_in, exp_pin71());
        end
        $display("test inputs done");
        sc.rx_en = 1'h1;
        pg.dir = 8'h00;
        ext_lvl = 8'h20;
        irq_en = 8'hff;
        repeat (7) @(negedge clk);
        sc.rx_en = 1'h0;
        ext_lvl = 8'h01;
        @(negedge clk);
        ext_lvl = 8'h00;
        repeat (8) begin
            @(negedge clk);
            chk(irq[0], 1'h0);
        end
        chk(rx, 1'h1);
        ext_en = 8'h00;
        repeat (6) @(negedge clk);
        chk({pg_in[5:0], irq[5:0]}, 12'h000);
        ext_en = 8'hff;
        rstn = 1'h0;
        @(negedge clk);
        chk({pad71, pg_oe, rx}, 24'h0);
        rstn = 1'h1;
        @(negedge clk);
        chk({6'h0, pad71, pg_out, pg_oe}, {6'h0, exp71(), exp_pg()});
        $display("test corners done");
        end_sim();
    end
endmodule : shared_pin_function_select_tb
